// >>> verilog/synth_pkg.sv
// Behaviour
// - first setting after power-up: 40 ms wait
// - later channel change: 10 to 20 ms wait
// - mode switch, same channel: 5 ms wait
// - serial data, clock and latch strobe set frequency
// - lock indicator shows synthesizer lock state
// - frequency = (M*N + A) * fosc / R
// - prescaler ratio is 64 or 128
// - 19-bit shift register, last bit picks latch
// - data captured on serial clock rising edge
// - strobe rise loads chosen latch, any order
package synth_pkg;
    localparam int SR_W = 19;
    localparam int N_W = 11;
    localparam int A_W = 7;
    localparam int R_W = 14;
    localparam int COUNT_W = 18;
    localparam int TIMER_W = 21;

    // word layout, last bit shifted sits at bit 0
    localparam int POS_TARGET = 0;
    localparam int POS_A_LSB = 1;
    localparam int POS_N_LSB = 8;
    localparam int POS_R_LSB = 1;
    localparam int POS_PRESC = 15;
    localparam int POS_POLARITY = 16;
    localparam int POS_LOCK_SEL = 17;
    localparam int POS_PUMP = 18;

    localparam logic [7:0] PRESC_SMALL = 8'h40;
    localparam logic [7:0] PRESC_LARGE = 8'h80;
    localparam logic [N_W-1:0] N_MIN = 11'h003;
    localparam logic [R_W-1:0] R_MIN = 14'h0003;
    localparam logic [SR_W-1:0] SR_RESET = 19'h00000;

    localparam int CLK_KHZ = 50000;
    localparam int POWERUP_WAIT_MS = 40;
    localparam int CHANGE_WAIT_MS = 20;
    localparam int MODE_WAIT_MS = 5;
    localparam int POWERUP_CYCLES = POWERUP_WAIT_MS * CLK_KHZ;
    localparam int CHANGE_CYCLES = CHANGE_WAIT_MS * CLK_KHZ;
    localparam int MODE_CYCLES = MODE_WAIT_MS * CLK_KHZ;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REF = 8'h08;
    localparam logic [7:0] ADDR_DIV = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam int CTRL_HOLD = 0;
    localparam int CTRL_CLR_VIOL = 1;
    localparam int DIV_A_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = srst ? '0 : d;
        next_q = srst ? '0 : meta;
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q <= next_q;
    end
endmodule

// >>> verilog/settle_timer.sv
`timescale 1ns/1ns
module settle_timer #(
    parameter int W = 21
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_busy;

    always_comb begin
        next_count = count;
        if (srst) begin
            next_count = '0;
        end else if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
        next_busy = (next_count != '0);
    end

    always_ff @(posedge clk) begin
        count <= next_count;
        busy <= next_busy;
    end
endmodule

// >>> verilog/synth_channel_programmer.sv
`timescale 1ns/1ns
module synth_channel_programmer
    import synth_pkg::*;
#(
    parameter int POWERUP_WAIT = POWERUP_CYCLES,
    parameter int CHANGE_WAIT = CHANGE_CYCLES,
    parameter int MODE_WAIT = MODE_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic LATCH_STROBE,
    input wire logic RECEIVE_SELECT,
    input wire logic TRANSMIT_SELECT,
    output logic LOCK_INDICATOR,
    output logic RX_READY,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    logic ser_clk_s;
    logic ser_data_s;
    logic strobe_s;
    logic rx_sel_s;
    logic tx_sel_s;
    logic ser_clk_d;
    logic strobe_d;
    logic rx_sel_d;
    logic tx_sel_d;
    logic [SR_W-1:0] shreg;
    logic [R_W-1:0] ref_div;
    logic presc_sel;
    logic polarity;
    logic lock_sel;
    logic pump_sel;
    logic [N_W-1:0] main_div;
    logic [A_W-1:0] swallow_div;
    logic [COUNT_W-1:0] total_count;
    logic ref_loaded;
    logic div_loaded;
    logic first_done;
    logic tx_violation;
    logic hold_lock;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic timer_load;
    logic [TIMER_W-1:0] timer_val;
    logic settling;

    logic next_ser_clk_d;
    logic next_strobe_d;
    logic next_rx_sel_d;
    logic next_tx_sel_d;
    logic [SR_W-1:0] next_shreg;
    logic [R_W-1:0] next_ref_div;
    logic next_presc_sel;
    logic next_polarity;
    logic next_lock_sel;
    logic next_pump_sel;
    logic [N_W-1:0] next_main_div;
    logic [A_W-1:0] next_swallow_div;
    logic [COUNT_W-1:0] next_total_count;
    logic next_ref_loaded;
    logic next_div_loaded;
    logic next_first_done;
    logic next_tx_violation;
    logic next_lock;
    logic next_rx_ready;
    logic next_hold_lock;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;

    logic ser_rise;
    logic strobe_rise;
    logic mode_change;
    logic load_ref;
    logic load_div;
    logic settings_valid;
    logic [7:0] presc_ratio;
    logic addr_phase;
    logic clr_viol;
    logic [31:0] read_mux;

    // every serial and select pin is foreign to REF_CLK
    pin_sync #(.W(5)) u_sync (
        .clk(REF_CLK),
        .srst(SRST),
        .d({SER_CLK, SER_DATA, LATCH_STROBE, RECEIVE_SELECT,
            TRANSMIT_SELECT}),
        .q({ser_clk_s, ser_data_s, strobe_s, rx_sel_s, tx_sel_s})
    );

    settle_timer #(.W(TIMER_W)) u_timer (
        .clk(REF_CLK),
        .srst(SRST),
        .load(timer_load),
        .load_val(timer_val),
        .busy(settling)
    );

    always_comb begin
        ser_rise = ser_clk_s & ~ser_clk_d;
        strobe_rise = strobe_s & ~strobe_d;
        load_ref = strobe_rise & shreg[POS_TARGET];
        load_div = strobe_rise & ~shreg[POS_TARGET];
        mode_change = (rx_sel_s != rx_sel_d) | (tx_sel_s != tx_sel_d);
        presc_ratio = presc_sel ? PRESC_SMALL : PRESC_LARGE;
        // lock only for settings the counters can really divide by
        settings_valid = (main_div >= N_MIN) & (ref_div >= R_MIN)
            & ({4'h0, swallow_div} <= main_div);
        addr_phase = HSEL & HTRANS[1] & HREADY;
        clr_viol = wr_pend & (wr_addr == ADDR_CTRL)
            & HWDATA[CTRL_CLR_VIOL];
    end

    // settle waits: a load always restarts, a pure mode switch
    // never shortens a longer wait already running
    always_comb begin
        timer_load = 1'b0;
        timer_val = '0;
        if (strobe_rise) begin
            timer_load = 1'b1;
            if (first_done) begin
                timer_val = TIMER_W'(CHANGE_WAIT);
            end else begin
                timer_val = TIMER_W'(POWERUP_WAIT);
            end
        end else if (mode_change && !settling) begin
            timer_load = 1'b1;
            timer_val = TIMER_W'(MODE_WAIT);
        end
    end

    always_comb begin
        next_ser_clk_d = ser_clk_s;
        next_strobe_d = strobe_s;
        next_rx_sel_d = rx_sel_s;
        next_tx_sel_d = tx_sel_s;
        next_shreg = shreg;
        next_ref_div = ref_div;
        next_presc_sel = presc_sel;
        next_polarity = polarity;
        next_lock_sel = lock_sel;
        next_pump_sel = pump_sel;
        next_main_div = main_div;
        next_swallow_div = swallow_div;
        next_ref_loaded = ref_loaded | load_ref;
        next_div_loaded = div_loaded | load_div;
        next_first_done = first_done | strobe_rise;
        next_tx_violation = tx_violation;
        if (ser_rise) begin
            next_shreg = {shreg[SR_W-2:0], ser_data_s};
        end
        if (load_ref) begin
            next_ref_div = shreg[POS_R_LSB +: R_W];
            next_presc_sel = shreg[POS_PRESC];
            next_polarity = shreg[POS_POLARITY];
            next_lock_sel = shreg[POS_LOCK_SEL];
            next_pump_sel = shreg[POS_PUMP];
        end
        if (load_div) begin
            next_main_div = shreg[POS_N_LSB +: N_W];
            next_swallow_div = shreg[POS_A_LSB +: A_W];
        end
        // loading in transmit is recorded; a new hit beats the clear
        if (clr_viol) begin
            next_tx_violation = 1'b0;
        end
        if (strobe_rise && tx_sel_s) begin
            next_tx_violation = 1'b1;
        end
        // n = M * N + A, the synthesizer multiplies fosc/R by it
        next_total_count = COUNT_W'(presc_ratio) * COUNT_W'(main_div)
            + COUNT_W'(swallow_div);
        // lock_sel high routes the divided output, not lock
        next_lock = ref_loaded & div_loaded & settings_valid & ~lock_sel
            & ~settling & ~strobe_rise & ~hold_lock;
        next_rx_ready = first_done & ~settling & ~timer_load
            & rx_sel_s & ~tx_sel_s;
        if (SRST) begin
            next_ser_clk_d = 1'b0;
            next_strobe_d = 1'b0;
            next_rx_sel_d = 1'b0;
            next_tx_sel_d = 1'b0;
            next_shreg = SR_RESET;
            next_ref_div = '0;
            next_presc_sel = 1'b0;
            next_polarity = 1'b0;
            next_lock_sel = 1'b0;
            next_pump_sel = 1'b0;
            next_main_div = '0;
            next_swallow_div = '0;
            next_total_count = '0;
            next_ref_loaded = 1'b0;
            next_div_loaded = 1'b0;
            next_first_done = 1'b0;
            next_tx_violation = 1'b0;
            next_lock = 1'b0;
            next_rx_ready = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        ser_clk_d <= next_ser_clk_d;
        strobe_d <= next_strobe_d;
        rx_sel_d <= next_rx_sel_d;
        tx_sel_d <= next_tx_sel_d;
        shreg <= next_shreg;
        ref_div <= next_ref_div;
        presc_sel <= next_presc_sel;
        polarity <= next_polarity;
        lock_sel <= next_lock_sel;
        pump_sel <= next_pump_sel;
        main_div <= next_main_div;
        swallow_div <= next_swallow_div;
        total_count <= next_total_count;
        ref_loaded <= next_ref_loaded;
        div_loaded <= next_div_loaded;
        first_done <= next_first_done;
        tx_violation <= next_tx_violation;
        LOCK_INDICATOR <= next_lock;
        RX_READY <= next_rx_ready;
    end

    // zero-wait slave: read data is fetched in the address phase
    always_comb begin
        case (HADDR[7:0])
            ADDR_CTRL: read_mux = {31'h0, hold_lock};
            ADDR_STATUS: read_mux = {25'h0, div_loaded, ref_loaded,
                first_done, tx_violation, settling, RX_READY,
                LOCK_INDICATOR};
            ADDR_REF: read_mux = {13'h0, pump_sel, lock_sel, polarity,
                presc_sel, ref_div, 1'b0};
            ADDR_DIV: read_mux = {9'h0, swallow_div, 5'h0, main_div};
            ADDR_COUNT: read_mux = {14'h0, total_count};
            default: read_mux = 32'h00000000;
        endcase
    end

    always_comb begin
        next_wr_pend = addr_phase & HWRITE;
        next_wr_addr = addr_phase ? HADDR[7:0] : wr_addr;
        next_hrdata = (addr_phase && !HWRITE) ? read_mux : HRDATA;
        next_hold_lock = hold_lock;
        if (wr_pend && wr_addr == ADDR_CTRL) begin
            next_hold_lock = HWDATA[CTRL_HOLD];
        end
        if (SRST) begin
            next_wr_pend = 1'b0;
            next_wr_addr = 8'h00;
            next_hrdata = 32'h00000000;
            next_hold_lock = CTRL_RESET[CTRL_HOLD];
        end
    end

    always_ff @(posedge REF_CLK) begin
        wr_pend <= next_wr_pend;
        wr_addr <= next_wr_addr;
        HRDATA <= next_hrdata;
        hold_lock <= next_hold_lock;
        HREADYOUT <= 1'b1;
        HRESP <= 1'b0;
    end
endmodule

// >>> tb/synth_checker_properties.sv
`timescale 1ns/1ns
module synth_checker #(
    parameter int POWERUP_WAIT = 400,
    parameter int CHANGE_WAIT = 200
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic LATCH_STROBE,
    input wire logic RECEIVE_SELECT,
    input wire logic TRANSMIT_SELECT,
    input wire logic LOCK_INDICATOR,
    input wire logic RX_READY,
    input wire logic HREADYOUT,
    input wire logic HRESP
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic stb_d;
    int since;
    int up;
    // cycles since the last strobe rise and since reset release
    always_ff @(posedge REF_CLK) begin
        stb_d <= LATCH_STROBE;
        since <= (SRST || (LATCH_STROBE && !stb_d)) ? 0 : since + 1;
        up <= SRST ? 0 : up + 1;
    end
    a_reset_quiet: assert property ($fell(SRST) |->
        !LOCK_INDICATOR && !RX_READY) else $error("output high after reset");
    a_lock_after_wait: assert property ($rose(LOCK_INDICATOR) |->
        since >= CHANGE_WAIT) else $error("lock before settling ended");
    a_first_wait: assert property ($rose(RX_READY) |->
        up >= POWERUP_WAIT) else $error("ready before power-up wait");
    a_strobe_drops_lock: assert property ($rose(LATCH_STROBE) |->
        ##8 !LOCK_INDICATOR [*8]) else $error("lock kept after load");
    a_tx_blocks_ready: assert property (TRANSMIT_SELECT [*5] |->
        !RX_READY) else $error("ready in transmit mode");
    a_rx_needed: assert property (!RECEIVE_SELECT [*5] |->
        !RX_READY) else $error("ready without receive mode");
    a_mode_wait: assert property ($fell(TRANSMIT_SELECT) |->
        ##8 !RX_READY [*8]) else $error("no wait after mode switch");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or not okay");
endmodule

bind synth_channel_programmer synth_checker #(
    .POWERUP_WAIT(POWERUP_WAIT), .CHANGE_WAIT(CHANGE_WAIT)
) u_chk (
    .REF_CLK(REF_CLK), .SRST(SRST), .LATCH_STROBE(LATCH_STROBE),
    .RECEIVE_SELECT(RECEIVE_SELECT), .TRANSMIT_SELECT(TRANSMIT_SELECT),
    .LOCK_INDICATOR(LOCK_INDICATOR), .RX_READY(RX_READY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP)
);

// >>> tb/synth_host_model.sv
`timescale 1ns/1ns
module synth_host_model (
    input wire logic clk,
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b1;
        latch_strobe = 1'b0;
    end
    // clock stands low between frames; 8 system clocks, 160 ns period
    task automatic send(input logic [18:0] w);
        for (int i = 18; i >= 0; i--) begin
            ser_data <= w[i];
            repeat (4) @(posedge clk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ser_clk <= 1'b0;
        end
        // line no longer meaningful: show the inverse, not a stale level
        ser_data <= ~w[0];
        repeat (4) @(posedge clk);
        latch_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        latch_strobe <= 1'b0;
    endtask
endmodule

// >>> tb/synth_channel_programmer_tb_top.sv
`timescale 1ns/1ns
module synth_channel_programmer_tb_top
    import synth_pkg::*;
;
    localparam int PW = 400;
    localparam int CW = 200;
    localparam int MW = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rx_sel = 1'b0;
    logic tx_sel = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    wire logic sck, sdat, stb, lock, rxr, hrdy, hresp;
    wire logic [31:0] hrdata;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    synth_channel_programmer #(
        .POWERUP_WAIT(PW), .CHANGE_WAIT(CW), .MODE_WAIT(MW)
    ) u_synth_channel_programmer (
        .REF_CLK(clk), .SRST(rst), .SER_CLK(sck), .SER_DATA(sdat),
        .LATCH_STROBE(stb), .RECEIVE_SELECT(rx_sel),
        .TRANSMIT_SELECT(tx_sel), .LOCK_INDICATOR(lock),
        .RX_READY(rxr), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp)
    );
    synth_host_model host (
        .clk(clk), .ser_clk(sck), .ser_data(sdat), .latch_strobe(stb)
    );

    task automatic tally_and_finish;
        $display("errors %0d, compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            err_count++;
            $display("ERROR %0t: got %h, want %h", $time, got, want);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // bounded wait for lock or ready, then check its delay
    task automatic settle(input int lo, input int hi, input bit pick);
        int n;
        n = 0;
        while ((pick ? lock : rxr) !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    function automatic logic [18:0] ref_w(input logic p64,
                                          input logic [13:0] r);
        return {3'h1, p64, r, 1'b1};
    endfunction
    function automatic logic [18:0] div_w(input logic [10:0] n,
                                          input logic [6:0] a);
        return {n, a, 1'b0};
    endfunction

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(8'h20, 32'h0);
        rx_sel <= 1'b1;
        host.send(ref_w(1'b1, 14'h0352));
        settle(PW - 10, PW + 4, 1'b0);
        rd(ADDR_STATUS, 32'h32);
        rd(ADDR_REF, 32'h186a4, 32'h7fffe);
        host.send(div_w(11'h002, 7'h01));
        repeat (CW + 20) @(posedge clk);
        chk({31'h0, lock}, 32'h0);
        rd(ADDR_DIV, 32'h00010002);
        // precomputed entry for one channel, 21.7 MHz below it
        host.send(div_w(11'h212, 7'h01));
        settle(CW - 10, CW + 4, 1'b1);
        rd(ADDR_COUNT, 32'h8481);
        rd(ADDR_DIV, 32'h00010212);
        wr(ADDR_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, lock}, 32'h0);
        rd(ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        chk({31'h0, lock}, 32'h1);
        host.send(ref_w(1'b0, 14'h0352));
        settle(CW - 10, CW + 4, 1'b1);
        rd(ADDR_COUNT, 32'h10901);
        tx_sel <= 1'b1;
        repeat (MW + 30) @(posedge clk);
        chk({31'h0, rxr}, 32'h0);
        tx_sel <= 1'b0;
        settle(MW - 2, MW + 8, 1'b0);
        tx_sel <= 1'b1;
        repeat (MW + 30) @(posedge clk);
        // load in transmit mode still lands but is flagged
        host.send(div_w(11'h212, 7'h7f));
        repeat (8) @(posedge clk);
        rd(ADDR_STATUS, 32'h8, 32'h8);
        rd(ADDR_DIV, 32'h007f0212);
        wr(ADDR_CTRL, 32'h2);
        rd(ADDR_STATUS, 32'h0, 32'h8);
        rd(ADDR_CTRL, 32'h0);
        tx_sel <= 1'b0;
        // lock pin routed to the divided output: no lock, wait shown
        host.send({3'h3, 1'b0, 14'h0352, 1'b1});
        rd(ADDR_STATUS, 32'h4, 32'h4);
        repeat (CW + 20) @(posedge clk);
        chk({31'h0, lock}, 32'h0);
        rd(ADDR_REF, 32'h306a4, 32'h7fffe);
        tally_and_finish();
    end
endmodule
